// file: core/mss_defines.vh
// Constants for the multimode synchronous serial channel.
`ifndef MSS_DEFINES_VH
`define MSS_DEFINES_VH
// Register byte offsets on the bus.
`define MSS_A_SREG 8'h00
`define MSS_A_SVA 8'h04
`define MSS_A_MODE 8'h08
`define MSS_A_BCTL 8'h0C
`define MSS_A_ITR 8'h10
`define MSS_A_PIN 8'h14
// Channel mode register fields.
`define MSS_M_EN 7
`define MSS_M_COI 6
`define MSS_M_WAKE 5
`define MSS_M_INT 4
`define MSS_M_LSB 3
`define MSS_M_SEL 2:0
// Operating mode codes.
`define MSS_MD_STOP 3'h0
`define MSS_MD_3W 3'h1
`define MSS_MD_SBI 3'h2
`define MSS_MD_2W 3'h3
`define MSS_MD_I2C 3'h4
// Bus control register fields.
`define MSS_B_BUSY_OUTPUT_ENABLE 7
`define MSS_B_BUSY 6
`define MSS_B_CLS 5:4
`define MSS_B_XFER 3
`define MSS_B_BUS_RELEASE_FLAG 2
// Interrupt timing register fields.
`define MSS_I_WAT 1:0
`define MSS_I_ACK 2
`define MSS_I_MASK 4
`define MSS_I_SIC 5
`define MSS_I_SCK 6
// Pin control register fields.
`define MSS_P_CLK 0
`define MSS_P_DAT 1
`define MSS_P_SELB 2
// Word classes.
`define MSS_C_DATA 2'h0
`define MSS_C_ADDR 2'h1
`define MSS_C_CMD 2'h2
// Bit counts and fixed values.
`define MSS_LAST8 4'h7
`define MSS_LAST9 4'h8
`define MSS_WAIT9 2'h3
`define MSS_ONES 8'hFF
`define MSS_RD_ZERO 32'h0000_0000
// Serial clock timing.
`define MSS_CLK_NS 10
`define MSS_HALF_NS 40
`endif

// file: core/mss_channel.v
// Multimode synchronous serial channel with a Wishbone register port.
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "mss_defines.vh"
module mss_channel (
  input wire i_clk, // System clock.
  input wire i_nrst, // Asynchronous reset, active low.
  input wire i_wb_cyc, // Bus cycle.
  input wire i_wb_stb, // Bus strobe.
  input wire i_wb_we, // Write enable.
  input wire [31:0] i_wb_adr, // Byte address.
  input wire [31:0] i_wb_dat, // Write data.
  input wire [3:0] i_wb_sel, // Byte enables.
  output wire o_wb_ack, // Bus acknowledge.
  output wire [31:0] o_wb_dat, // Read data.
  input wire i_serial_clock_pin, // Clock pin level.
  output wire o_serial_clock_pin, // Clock pin drive.
  output wire o_serial_clock_pin_oe, // Clock pin enable.
  input wire i_bus_data_line_a, // Line A level.
  output wire o_bus_data_line_a, // Line A drive.
  output wire o_bus_data_line_a_oe, // Line A enable.
  input wire i_bus_data_line_b, // Line B level.
  output wire o_bus_data_line_b, // Line B drive.
  output wire o_bus_data_line_b_oe, // Line B enable.
  output wire o_channel_interrupt_request // Interrupt pulse.
);

  // ==========================================================
  // Constants
  // ==========================================================
  // Half period of the internal serial clock in system cycles.
  localparam integer HALF_CYC =
    (`MSS_HALF_NS + `MSS_CLK_NS - 1) / `MSS_CLK_NS;
  localparam [7:0] HALF_M1 = HALF_CYC[7:0] - 8'h01; // Reload.

  // ==========================================================
  // Reset synchroniser
  // ==========================================================
  reg [1:0] rst_q; // Release shift chain.
  wire rst_n; // Synchronised reset, active low.

  // Releases reset two edges after the pin goes high.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  wire [2:0] pin_raw; // Clock, line A, line B.
  wire [2:0] pin_s; // Synchronised levels.
  wire [2:0] pin_p; // Levels one cycle earlier.
  genvar g;

  assign pin_raw = {i_bus_data_line_b, i_bus_data_line_a,
                    i_serial_clock_pin};

  // Two flops per pin, then one more flop for edge finding.
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      reg m_q; // First stage, read only by the second.
      reg s_q; // Second stage.
      reg p_q; // Previous synchronised level.
      always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          m_q <= 1'b1;
          s_q <= 1'b1;
          p_q <= 1'b1;
        end else begin
          m_q <= pin_raw[g];
          s_q <= m_q;
          p_q <= s_q;
        end
      end
      assign pin_s[g] = s_q;
      assign pin_p[g] = p_q;
    end
  endgenerate

  // ==========================================================
  // Register address decode
  // ==========================================================
  // Returns a one-hot select for the six registers.
  function [5:0] dec;
    input [31:0] adr;
    begin
      case (adr[7:0])
        `MSS_A_SREG: dec = 6'h01;
        `MSS_A_SVA: dec = 6'h02;
        `MSS_A_MODE: dec = 6'h04;
        `MSS_A_BCTL: dec = 6'h08;
        `MSS_A_ITR: dec = 6'h10;
        `MSS_A_PIN: dec = 6'h20;
        default: dec = 6'h00;
      endcase
      if (adr[31:8] != 24'h00_0000) begin
        dec = 6'h00;
      end
    end
  endfunction

  // ==========================================================
  // State
  // ==========================================================
  reg ack_q; // Bus acknowledge.
  reg [31:0] rdat_q; // Bus read data.
  reg en_q; // Operation enable.
  reg coi_q; // Address coincidence flag.
  reg wake_q; // Wake-up enable.
  reg intclk_q; // Internal clock select.
  reg lsbf_q; // LSB first in 3-wire mode.
  reg [2:0] mode_q; // Operating mode.
  reg busy_output_enable_q; // Busy output enable.
  reg busy_q; // Busy state, holds the line low.
  reg bus_release_flag_q; // Bus release flag.
  reg [1:0] cls_q; // Class of the last word.
  reg [1:0] nxt_q; // Class of the next word.
  reg [1:0] wat_q; // Wait select bits.
  reg mask_q; // Address LSB mask.
  reg sic_q; // Interrupt cause select.
  reg ack9_q; // Level seen on the ninth clock.
  reg clat_q; // Software clock level latch.
  reg dlat_q; // Data output latch.
  reg lsel_q; // Use line B as the shared line.
  reg [7:0] sreg_q; // Serial shift register.
  reg [7:0] sva_q; // Slave address compare.
  reg xfer_q; // Transfer in progress.
  reg [3:0] cnt_q; // Serial clock counter.
  reg gen_q; // Internal clock level.
  reg [7:0] div_q; // Internal clock divider.
  reg irq_q; // Interrupt pulse.
  reg sck_o_q; // Clock pin drive.
  reg sck_oe_q; // Clock pin enable.
  reg a_oe_q; // Line A enable.
  reg b_o_q; // Line B drive.
  reg b_oe_q; // Line B enable.

  // ==========================================================
  // Decode and mode terms
  // ==========================================================
  wire req = i_wb_cyc & i_wb_stb & ~ack_q; // New request.
  wire [5:0] hit = dec(i_wb_adr); // Register select.
  wire wr = req & i_wb_we & i_wb_sel[0]; // Byte 0 write.
  wire [7:0] wd = i_wb_dat[7:0]; // Write byte.
  wire three = (mode_q == `MSS_MD_3W); // 3-wire mode.
  wire addressed_twoline_bus_mode = (mode_q == `MSS_MD_SBI); // Addressed bus.
  wire two = (mode_q == `MSS_MD_2W); // Software format.
  wire i2c = (mode_q == `MSS_MD_I2C); // I2C-style mode.
  wire shared = addressed_twoline_bus_mode | two | i2c; // One shared data line.
  // Stop mode or disable halts every transfer.
  wire run = en_q & (mode_q != `MSS_MD_STOP);
  wire eff_lsb = three & lsbf_q; // Others are MSB first.
  wire wake_eff = wake_q & ~sic_q & (addressed_twoline_bus_mode | i2c);
  // Nine clocks with both waits set in I2C.
  wire nine = i2c & (wat_q == `MSS_WAIT9);
  wire [3:0] last_cnt = nine ? `MSS_LAST9 : `MSS_LAST8;

  // ==========================================================
  // Serial clock edges
  // ==========================================================
  wire sck_s = pin_s[0]; // Clock pin level.
  wire din = (three | ~lsel_q) ? pin_s[1] : pin_s[2]; // In.
  wire din_p = (three | ~lsel_q) ? pin_p[1] : pin_p[2];
  wire tick = xfer_q & intclk_q & (div_q == 8'h00);
  // The selected clock is the only one reaching the shifter.
  wire rise = xfer_q & (intclk_q ? (tick & ~gen_q) :
                        (sck_s & ~pin_p[0]));
  wire fall = xfer_q & (intclk_q ? (tick & gen_q) :
                        (~sck_s & pin_p[0]));
  wire byte_done = rise & (cnt_q == `MSS_LAST8);
  wire word_end = rise & (cnt_q == last_cnt);

  // ==========================================================
  // Bus conditions and address compare
  // ==========================================================
  wire cond_hi = shared & run & sck_s & pin_p[0]; // Clock high.
  wire relstop = cond_hi & din & ~din_p; // Release or stop.
  wire startcmd = cond_hi & ~din & din_p; // Command or start.
  // Incoming bit enters at the far end from the outgoing one.
  wire [7:0] shin = eff_lsb ? {din, sreg_q[7:1]} :
                              {sreg_q[6:0], din};
  wire outbit = eff_lsb ? sreg_q[0] : sreg_q[7];
  // Compare the whole byte, or only the upper seven bits.
  wire m = mask_q ? (shin[7:1] == sva_q[7:1]) :
                    (shin == sva_q);
  wire is_addr = byte_done ? (nxt_q == `MSS_C_ADDR) :
                             (cls_q == `MSS_C_ADDR);
  wire coi_now = byte_done ? m : coi_q;
  // Word interrupt: every word, or only a matching address.
  wire irq_w = word_end & (~wake_eff | (is_addr & coi_now));
  wire irq_c = sic_q & relstop;
  wire go = wr & hit[0] & run; // Software start.
  // Wake-up receiver arms itself on release or start.
  wire arm = wake_eff & ~intclk_q & ~xfer_q &
             (addressed_twoline_bus_mode ? relstop : (i2c & startcmd));

  // ==========================================================
  // Bus slave
  // ==========================================================
  // Answers every request one cycle later, unmapped reads zero.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= `MSS_RD_ZERO;
    end else begin
      ack_q <= req;
      rdat_q <= `MSS_RD_ZERO;
      if (req) begin
        // Each register sits in the low byte of its word.
        case (1'b1)
          hit[0]: rdat_q[7:0] <= sreg_q;
          hit[1]: rdat_q[7:0] <= sva_q;
          hit[2]: rdat_q[7:0] <= {en_q, coi_q, wake_q,
                                  intclk_q, lsbf_q, mode_q};
          hit[3]: rdat_q[7:0] <= {busy_output_enable_q, busy_q, cls_q,
                                  xfer_q, bus_release_flag_q, 2'h0};
          hit[4]: rdat_q[7:0] <= {1'b0, sck_s, sic_q, mask_q,
                                  1'b0, ack9_q, wat_q};
          hit[5]: rdat_q[7:0] <= {5'h00, lsel_q, dlat_q,
                                  clat_q};
          default: rdat_q[7:0] <= 8'h00;
        endcase
      end
    end
  end
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // ==========================================================
  // Control registers written by software
  // ==========================================================
  // Plain configuration fields with no hardware writer.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      wake_q <= 1'b0;
      intclk_q <= 1'b0;
      lsbf_q <= 1'b0;
      mode_q <= `MSS_MD_STOP;
      busy_output_enable_q <= 1'b0;
      wat_q <= 2'h0;
      mask_q <= 1'b0;
      sic_q <= 1'b0;
      clat_q <= 1'b1;
      lsel_q <= 1'b0;
      sva_q <= 8'h00;
    end else if (wr) begin
      if (hit[1]) begin
        sva_q <= wd;
      end
      if (hit[2]) begin
        en_q <= wd[`MSS_M_EN];
        wake_q <= wd[`MSS_M_WAKE];
        intclk_q <= wd[`MSS_M_INT];
        lsbf_q <= wd[`MSS_M_LSB];
        // A mode change while enabled is dropped.
        if (!en_q) begin
          mode_q <= wd[`MSS_M_SEL];
        end
      end
      if (hit[3]) begin
        busy_output_enable_q <= wd[`MSS_B_BUSY_OUTPUT_ENABLE];
      end
      if (hit[4]) begin
        wat_q <= wd[`MSS_I_WAT];
        mask_q <= wd[`MSS_I_MASK];
        sic_q <= wd[`MSS_I_SIC];
      end
      if (hit[5]) begin
        // Direct clock level for software formats.
        clat_q <= wd[`MSS_P_CLK];
        lsel_q <= wd[`MSS_P_SELB];
      end
    end
  end

  // ==========================================================
  // Shift engine, counter, flags and interrupt
  // ==========================================================
  // Later assignments win, so hardware events beat writes.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sreg_q <= 8'h00;
      xfer_q <= 1'b0;
      cnt_q <= 4'h0;
      gen_q <= 1'b1;
      div_q <= 8'h00;
      dlat_q <= 1'b1;
      coi_q <= 1'b0;
      busy_q <= 1'b0;
      bus_release_flag_q <= 1'b0;
      cls_q <= `MSS_C_DATA;
      nxt_q <= `MSS_C_DATA;
      ack9_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_q <= 1'b0;
      // Software sets the data latch directly when idle.
      if (wr & hit[5] & ~xfer_q) begin
        dlat_q <= wd[`MSS_P_DAT];
      end
      // A shift write loads the word and, when the channel runs, starts shifting.
      if (wr & hit[0]) begin
        sreg_q <= wd;
        busy_q <= 1'b0; // Busy enable stays as it is.
        if (go) begin
          xfer_q <= 1'b1;
          cnt_q <= 4'h0;
          gen_q <= 1'b1;
          div_q <= HALF_M1;
          dlat_q <= eff_lsb ? wd[0] : wd[7]; // First bit.
        end
      end
      // Wake-up reception needs no shift write.
      if (arm) begin
        sreg_q <= `MSS_ONES;
        xfer_q <= 1'b1;
        cnt_q <= 4'h0;
        dlat_q <= 1'b1;
      end
      // Internal clock divider toggles the clock level.
      if (xfer_q & intclk_q) begin
        if (tick) begin
          div_q <= HALF_M1;
          gen_q <= ~gen_q;
        end else begin
          div_q <= div_q - 8'h01;
        end
      end
      // Falling edge presents the next outgoing bit.
      if (fall & (cnt_q != 4'h0)) begin
        dlat_q <= (cnt_q == `MSS_LAST9) ? 1'b1 : outbit;
      end
      // Rising edge captures the incoming bit.
      if (rise) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == `MSS_LAST9) begin
          ack9_q <= din; // Acknowledge slot.
        end else begin
          sreg_q <= shin;
        end
      end
      // Word classification at the end of each byte.
      if (byte_done & shared) begin
        cls_q <= nxt_q;
        nxt_q <= `MSS_C_DATA;
        if (nxt_q == `MSS_C_ADDR) begin
          // Address words select a slave first.
          coi_q <= m;
          if (!m) begin
            bus_release_flag_q <= 1'b0;
          end
        end
      end
      // Word end closes the transfer.
      if (word_end) begin
        xfer_q <= 1'b0;
        if (addressed_twoline_bus_mode) begin
          dlat_q <= 1'b1;
          busy_q <= busy_output_enable_q;
        end
        irq_q <= irq_w;
      end
      // Line conditions while the clock is high.
      if (relstop) begin
        nxt_q <= `MSS_C_ADDR;
        if (addressed_twoline_bus_mode) begin
          bus_release_flag_q <= 1'b1;
        end
        if (irq_c) begin
          irq_q <= 1'b1;
        end
      end
      if (startcmd) begin
        nxt_q <= addressed_twoline_bus_mode ? `MSS_C_CMD : `MSS_C_ADDR;
      end
      // Disable or stop mode abandons a transfer.
      if (!run) begin
        xfer_q <= 1'b0;
        busy_q <= 1'b0;
        gen_q <= 1'b1;
      end
    end
  end
  assign o_channel_interrupt_request = irq_q;

  // ==========================================================
  // Pin drivers
  // ==========================================================
  wire clk_lvl = (xfer_q & intclk_q) ? gen_q : clat_q;
  wire dlv = dlat_q & ~busy_q; // Busy pulls the line low.

  // Push-pull in 3-wire mode, open drain on shared lines.
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_o_q <= 1'b0;
      sck_oe_q <= 1'b0;
      a_oe_q <= 1'b0;
      b_o_q <= 1'b0;
      b_oe_q <= 1'b0;
    end else begin
      // Internal clock appears on the pin.
      sck_o_q <= three & clk_lvl;
      sck_oe_q <= run & intclk_q & (three | ~clk_lvl);
      a_oe_q <= run & shared & ~lsel_q & ~dlv;
      b_o_q <= three & dlat_q;
      b_oe_q <= run & (three | (shared & lsel_q & ~dlv));
    end
  end
  assign o_serial_clock_pin = sck_o_q;
  assign o_serial_clock_pin_oe = sck_oe_q;
  assign o_bus_data_line_a = 1'b0;
  assign o_bus_data_line_a_oe = a_oe_q;
  assign o_bus_data_line_b = b_o_q;
  assign o_bus_data_line_b_oe = b_oe_q;

endmodule

// file: dv/mss_channel_props.sv
// Port-level checks for the serial channel, bound into its top module.
`timescale 1ns/1ns
module mss_channel_chk (
  input wire i_clk, // System clock.
  input wire i_nrst, // Reset, active low.
  input wire i_wb_cyc, // Bus cycle.
  input wire i_wb_stb, // Bus strobe.
  input wire i_wb_we, // Write enable.
  input wire [31:0] i_wb_adr, // Byte address.
  input wire [31:0] i_wb_dat, // Write data.
  input wire [3:0] i_wb_sel, // Byte enables.
  input wire o_wb_ack, // Bus acknowledge.
  input wire o_serial_clock_pin, // Clock pin drive.
  input wire o_serial_clock_pin_oe, // Clock pin enable.
  input wire o_bus_data_line_a_oe, // Line A enable.
  input wire o_bus_data_line_b, // Line B drive.
  input wire o_channel_interrupt_request // Interrupt pulse.
);
  // ==========================================================
  // Helper state rebuilt from bus writes and pin activity.
  reg [7:0] mode_q; // Mode register as software set it.
  reg clk_p_q; // Clock wire level one cycle ago.
  reg [3:0] rise_q; // Driven clock rises since the last shift write.
  reg [3:0] off_q; // Cycles spent with the channel disabled.
  wire wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & i_wb_sel[0];
  wire wr_sreg = wr & (i_wb_adr == 32'h0000_0000);
  wire wr_mode = wr & (i_wb_adr == 32'h0000_0008);
  wire rise = o_serial_clock_pin_oe & o_serial_clock_pin & ~clk_p_q;
  wire m3i = mode_q[7] & mode_q[4] & (mode_q[2:0] == 3'h1);
  wire sbix = mode_q[7] & ~mode_q[4] & (mode_q[2:0] == 3'h2);
  wire [3:0] rise_now = rise_q + {3'h0, rise};
  // The mode field keeps its value while the channel is enabled.
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q <= 8'h00;
      clk_p_q <= 1'b1;
      rise_q <= 4'h0;
      off_q <= 4'h0;
    end else begin
      if (wr_mode) begin
        mode_q <= {i_wb_dat[7], 1'b0, i_wb_dat[5:3],
                   mode_q[7] ? mode_q[2:0] : i_wb_dat[2:0]};
      end
      clk_p_q <= o_serial_clock_pin | ~o_serial_clock_pin_oe;
      if (wr_sreg) begin
        rise_q <= 4'h0;
      end else if (rise && rise_q != 4'hF) begin
        rise_q <= rise_q + 4'h1;
      end
      off_q <= mode_q[7] ? 4'h0 : (off_q == 4'hF ? off_q : off_q + 4'h1);
    end
  end
  // ==========================================================
  // Assertions.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // The first driven clock low follows a shift write within eight cycles.
  chk_clock_starts: assert property (
    wr_sreg && m3i |-> ##[1:8] (o_serial_clock_pin_oe && !o_serial_clock_pin))
    else $error("internal clock not driven after shift write");
  // The pin shows the eighth rise one cycle after the interrupt pulse.
  chk_eight_clocks: assert property (
    o_channel_interrupt_request && m3i |=> rise_now == 4'h8)
    else $error("word interrupt not after eight clocks");
  chk_bit_settled: assert property (
    m3i && rise && $past(o_serial_clock_pin_oe) |->
    $stable(o_bus_data_line_b))
    else $error("data out moved on a rising clock");
  chk_irq_pulse: assert property (
    o_channel_interrupt_request |=> !o_channel_interrupt_request)
    else $error("interrupt longer than one cycle");
  chk_off_quiet: assert property (
    off_q > 4'h4 |-> !o_channel_interrupt_request)
    else $error("interrupt while disabled");
  chk_no_xfer_off: assert property (
    wr_sreg && !mode_q[7] |=> (rise_q == 4'h0) [*8])
    else $error("clock ran after write while disabled");
  chk_line_a_input: assert property (m3i |-> !o_bus_data_line_a_oe)
    else $error("serial input line driven in three-wire mode");
  chk_ext_no_clock: assert property (
    sbix && $past(sbix, 2) |-> !o_serial_clock_pin_oe)
    else $error("clock driven with external clock selected");
  cover property (o_channel_interrupt_request && m3i);
  cover property (o_channel_interrupt_request && sbix);
  cover property (wr_mode && mode_q[7]);
  cover property (o_channel_interrupt_request && mode_q[2:0] == 3'h4);
endmodule
bind mss_channel mss_channel_chk u_chk (.i_clk, .i_nrst, .i_wb_cyc,
  .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_ack,
  .o_serial_clock_pin, .o_serial_clock_pin_oe, .o_bus_data_line_a_oe,
  .o_bus_data_line_b, .o_channel_interrupt_request);

// file: dv/mss_peer_model.sv
// Behavioural peripheral and bus master on the channel's serial lines.
`timescale 1ns/1ns
module mss_peer_model (
  input wire i_sck, // Clock wire level.
  input wire i_sdo, // Level of the channel's data out line.
  input wire [7:0] i_tx, // Reply word for a clocked exchange.
  input wire i_lsb, // Shift the low bit first.
  input wire i_load, // Rising edge loads the reply word.
  output reg o_sck, // Clock drive when acting as master.
  output reg o_sda, // Data drive; high lets the pull-up win.
  output reg [7:0] o_rx // Word gathered from the channel.
);
  reg [7:0] sh; // Reply bits still to send.
  reg [3:0] falls; // Falling edges seen in this word.
  reg mst; // High while this side makes the clock.
  initial begin
    o_sck = 1'b1;
    o_sda = 1'b1;
    o_rx = 8'h00;
    sh = 8'hFF;
    falls = 4'h0;
    mst = 1'b0;
  end
  // Loading presents the first reply bit before any clock edge.
  always @(posedge i_load) begin
    sh = i_tx;
    falls = 4'h0;
    o_sda = i_lsb ? i_tx[0] : i_tx[7];
  end
  // Later falling edges step to the next bit, full duplex.
  always @(negedge i_sck) begin
    if (!mst) begin
      if (falls != 4'h0) begin
        sh = i_lsb ? {1'b1, sh[7:1]} : {sh[6:0], 1'b1};
      end
      falls = falls + 4'h1;
      o_sda = i_lsb ? sh[0] : sh[7];
    end
  end
  // Incoming bits are taken on the rising edge.
  always @(posedge i_sck) begin
    if (!mst) begin
      o_rx = i_lsb ? {i_sdo, o_rx[7:1]} : {o_rx[6:0], i_sdo};
    end
  end
  // A release condition, then an address word MSB first.
  task send_addr(input [7:0] b);
    integer i;
    begin
      mst = 1'b1;
      #3;
      o_sda = 1'b0;
      #40;
      o_sda = 1'b1;
      #40;
      for (i = 7; i >= 0; i = i - 1) begin
        o_sck = 1'b0;
        #20;
        o_sda = b[i];
        #20;
        o_sck = 1'b1;
        #40;
      end
      mst = 1'b0;
    end
  endtask
endmodule

// file: dv/tb_multimode_sync_serial_channel.sv
// Self-checking bench for the multimode serial channel.
`timescale 1ns/1ns
`include "mss_defines.vh"
module tb_multimode_sync_serial_channel;
  reg i_clk, i_nrst, cyc, stb, we, load, lsb; // Bench drives.
  reg [31:0] adr, wdat, q; // Bus address, write data, read data.
  reg [3:0] sel; // Byte enables.
  reg [7:0] tx; // Reply word for the peripheral.
  wire ack, sck_o, sck_oe, a_o, a_oe, b_o, b_oe, irq, p_sck, p_sda;
  wire [31:0] rdat; // Read data from the channel.
  wire [7:0] p_rx; // Word the peripheral gathered.
  integer num_errors, checked, base;
  integer irq_cnt = 0; // Interrupt pulses seen, counted by one process.
  // Wire levels: the clock and both data lines have pull-ups.
  wire clk_w = sck_oe ? sck_o : p_sck;
  wire a_w = a_oe ? a_o : p_sda;
  wire b_w = b_oe ? b_o : 1'b1;
  mss_channel dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
    .i_wb_sel(sel), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_serial_clock_pin(clk_w), .o_serial_clock_pin(sck_o),
    .o_serial_clock_pin_oe(sck_oe), .i_bus_data_line_a(a_w),
    .o_bus_data_line_a(a_o), .o_bus_data_line_a_oe(a_oe),
    .i_bus_data_line_b(b_w), .o_bus_data_line_b(b_o),
    .o_bus_data_line_b_oe(b_oe), .o_channel_interrupt_request(irq));
  mss_peer_model peer (.i_sck(clk_w), .i_sdo(b_w), .i_tx(tx),
    .i_lsb(lsb), .i_load(load), .o_sck(p_sck), .o_sda(p_sda), .o_rx(p_rx));
  // ==========================================================
  // Clock and interrupt pulse counter.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  // ==========================================================
  // Shared tasks.
  task end_sim;
    begin
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task timed_out;
    begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim;
    end
  endtask
  // One classic cycle, held until ack is sampled high.
  task wb(input w, input [7:0] a, input [7:0] d);
    integer n;
    begin
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {24'h00_0000, a};
      wdat <= {24'h00_0000, d};
      n = 0;
      @(posedge i_clk);
      while (ack !== 1'b1) begin
        n = n + 1;
        if (n > 20) timed_out;
        @(posedge i_clk);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task wait_irq(input integer lim);
    integer n;
    begin
      n = 0;
      while (irq_cnt == base && n < lim) begin
        @(posedge i_clk);
        n = n + 1;
      end
    end
  endtask
  // ==========================================================
  // Scenarios.
  task t_regs;
    begin
      wb(0, `MSS_A_MODE, 8'h00);
      cmp(q, 32'h0000_0000);
      wb(1, `MSS_A_SVA, 8'h5A);
      wb(0, `MSS_A_SVA, 8'h00);
      cmp(q, 32'h0000_005A);
      wb(1, `MSS_A_MODE, 8'h40);
      wb(0, `MSS_A_MODE, 8'h00);
      cmp(q, 32'h0000_0000);
      wb(1, 8'h20, 8'h77);
      wb(0, 8'h20, 8'h00);
      cmp(q, 32'h0000_0000);
    end
  endtask
  task t_mode_lock;
    begin
      wb(1, `MSS_A_MODE, 8'h91);
      wb(1, `MSS_A_MODE, 8'h94);
      wb(0, `MSS_A_MODE, 8'h00);
      cmp(q, 32'h0000_0091);
    end
  endtask
  task t_disabled;
    begin
      wb(1, `MSS_A_MODE, 8'h00);
      wb(1, `MSS_A_MODE, 8'h11);
      base = irq_cnt;
      wb(1, `MSS_A_SREG, 8'hC3);
      repeat (120) @(posedge i_clk);
      cmp(irq_cnt - base, 0);
    end
  endtask
  task t_three_wire(input [7:0] m, input [7:0] d, input [7:0] r);
    begin
      wb(1, `MSS_A_MODE, 8'h00);
      wb(1, `MSS_A_MODE, m);
      tx <= r;
      lsb <= m[3];
      @(posedge i_clk);
      load <= 1'b1;
      @(posedge i_clk);
      load <= 1'b0;
      base = irq_cnt;
      wb(1, `MSS_A_SREG, d);
      wait_irq(300);
      if (irq_cnt == base) timed_out;
      repeat (4) @(posedge i_clk);
      cmp(irq_cnt - base, 1);
      wb(0, `MSS_A_SREG, 8'h00);
      cmp(q, {24'h00_0000, r});
      cmp({24'h00_0000, p_rx}, {24'h00_0000, d});
    end
  endtask
  // Wake-up address reception in the addressed bus or I2C-style mode.
  task t_sbi(input [7:0] slave_address_compare, input [7:0] itr, input [7:0] a, input m,
    input [7:0] md);
    begin
      wb(1, `MSS_A_MODE, 8'h00);
      wb(1, `MSS_A_SVA, slave_address_compare);
      wb(1, `MSS_A_ITR, itr);
      wb(1, `MSS_A_PIN, 8'h03);
      wb(1, `MSS_A_MODE, md);
      base = irq_cnt;
      // No shift write: wake-up receives the address by itself.
      peer.send_addr(a);
      wait_irq(30);
      cmp(irq_cnt - base, m);
      wb(0, `MSS_A_MODE, 8'h00);
      cmp(q, {24'h00_0000, md | {1'b0, m, 6'h00}});
      wb(0, `MSS_A_BCTL, 8'h00);
      cmp(q & 32'h34, (m & md[1]) ? 32'h14 : 32'h10);
    end
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    num_errors = 0;
    checked = 0;
    base = 0;
    i_nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0000_0000;
    wdat = 32'h0000_0000;
    sel = 4'hF;
    tx = 8'h00;
    lsb = 1'b0;
    load = 1'b0;
    repeat (16) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_regs;
    t_mode_lock;
    t_disabled;
    t_three_wire(8'h91, 8'hB4, 8'h1E);
    t_three_wire(8'h99, 8'hB4, 8'h1E);
    t_three_wire(8'h91, 8'h0F, 8'hF0);
    t_sbi(8'h53, 8'h00, 8'h53, 1'b1, 8'hA2);
    t_sbi(8'h53, 8'h00, 8'h55, 1'b0, 8'hA2);
    t_sbi(8'h52, 8'h10, 8'h53, 1'b1, 8'hA2);
    t_sbi(8'h52, 8'h00, 8'h53, 1'b0, 8'hA2);
    t_sbi(8'h53, 8'h00, 8'h53, 1'b1, 8'hA4);
    t_sbi(8'h53, 8'h00, 8'h55, 1'b0, 8'hA4);
    end_sim;
  end
endmodule
